// ===== src/psl_lock_ctrl.v
// What this block does and what software must do
// RULE1: one-way mode blocks clearing lock once set
// RULE2: locked: unlock ignored once sticky (one-way mode), mapping writes blocked
// RULE3: only reset clears the one-way sticky lock
// RULE4: unprogrammed one-way: single session; else unlimited
// RULE5: reset inputs all ones, outputs all zeros
// RULE6: input reset picks pin 31 regardless
// RULE7: lock resets unlocked, mapping writable at once
// RULE8: software should lock after mapping setup
// RULE9: software issues unlock keys with tight timing
// RULE10: mapping leaves other pin settings untouched
// RULE11: mapping never enables the peripheral
// RULE12: mapping never overrides analog pin mode
// RULE13: software parks unused inputs and outputs
// RULE14: keys 46h then 57h, then lock change
// RULE15: locked mapping writes accepted but ignored
// RULE16: shadow compare raises configuration mismatch reset
// RULE17: one-way bit sampled on first clock after reset release; sticky flag
`timescale 1ns/1ps
`default_nettype none
`include "psl_regs.vh"

module psl_lock_ctrl #(
	parameter N_IN  = 8,      // input mapping fields
	parameter N_OUT = 8,      // output mapping fields
	parameter IAW   = 3,      // input index width
	parameter OAW   = 3       // output index width
) (
	input  wire                  ref_clk,          // system clock
	input  wire                  rst,              // async reset, high
	input  wire                  one_way_lock_cfg, // static config bit
	input  wire [7:0]            addr,             // register address
	input  wire [15:0]           wdata,            // write data
	input  wire                  wr,               // write strobe
	input  wire                  rd,               // read strobe
	output reg  [15:0]           rdata,            // read data, next cycle
	output wire [N_IN*5-1:0]     input_map_regs,   // input selections
	output wire [N_OUT*5-1:0]    output_map_regs,  // output selections
	output wire                  pin_map_lock,     // lock state
	output reg                   cfg_mismatch_rst  // mismatch reset request
);

	// Unlock key sequence states, one-hot
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_KEY1 = 3'b010;
	localparam [2:0] S_OPEN = 3'b100;

	reg  [2:0]  key_q;
	reg  [2:0]  key_d;
	reg         lock_q;
	reg         lock_d;
	reg         sticky_q;
	reg         oneway_q;
	reg         cfg_seen_q;
	reg         sel_q;
	reg  [1:0]  rsrc_q;
	wire        osc_wr;
	wire        in_wr;
	wire        out_wr;
	wire        in_hit;
	wire        out_hit;
	wire [4:0]  in_rd;
	wire [4:0]  out_rd;
	wire        in_mis;
	wire        out_mis;
	wire        lock_req;
	wire        lock_cmd;

	assign osc_wr  = wr && (addr == `PSL_OSC_CTRL_ADDR);
	assign in_hit  = (addr >= `PSL_IN_MAP_BASE) &&
	                 (addr <  `PSL_IN_MAP_BASE + N_IN);
	assign out_hit = (addr >= `PSL_OUT_MAP_BASE) &&
	                 (addr <  `PSL_OUT_MAP_BASE + N_OUT);
	// Locked writes complete normally but change nothing
	assign in_wr   = wr && in_hit && !lock_q;  // see RULE15
	assign out_wr  = wr && out_hit && !lock_q; // see RULE2
	assign lock_req = wdata[`PSL_LOCK_BIT];
	assign lock_cmd = osc_wr && (key_q == S_OPEN);

	// One-way bit held as a static level; caught after reset release
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			oneway_q   <= 1'b1;
			cfg_seen_q <= 1'b0;
		end else if (!cfg_seen_q) begin
			oneway_q   <= one_way_lock_cfg; // see RULE17
			cfg_seen_q <= 1'b1;
		end
	end

	// Key sequencer: 46h, 57h, then exactly one lock write
	always @* begin
		key_d = key_q;
		if (osc_wr) begin
			case (key_q)
			S_IDLE: key_d = (wdata[7:0] == `PSL_KEY_FIRST) ?
			                S_KEY1 : S_IDLE; // see RULE14
			S_KEY1: key_d = (wdata[7:0] == `PSL_KEY_SECOND) ?
			                S_OPEN : S_IDLE;
			S_OPEN: key_d = S_IDLE;
			default: key_d = S_IDLE;
			endcase
		end
	end

	// Lock next value; sticky lock refuses a clear
	always @* begin
		lock_d = lock_q;
		if (lock_cmd) begin
			if (lock_req)
				lock_d = 1'b1;
			else if (!sticky_q)
				lock_d = 1'b0; // see RULE1
		end
	end

	// Lock, sticky flag and key state; all reset unlocked
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			key_q    <= S_IDLE;
			lock_q   <= 1'b0; // see RULE7
			sticky_q <= 1'b0; // see RULE3
		end else begin
			key_q  <= key_d;
			lock_q <= lock_d;
			// One-way mode: first lock sticks until reset
			if (oneway_q && lock_cmd && lock_req)
				sticky_q <= 1'b1; // see RULE4
		end
	end

	assign pin_map_lock = lock_q;

	// Input fields reset to all ones: top pin, present or not
	psl_map_mem #(
		.N   (N_IN),
		.AW  (IAW),
		.RST (`PSL_IN_MAP_RST)
	) u_in_map (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.wr_en    (in_wr),
		.wr_idx   (addr[IAW-1:0]),
		.wr_data  (wdata[4:0]),
		.rd_idx   (addr[IAW-1:0]),
		.rd_data  (in_rd),
		.map_flat (input_map_regs), // see RULE6
		.mismatch (in_mis)
	);

	// Output fields reset to null, pins disconnected
	psl_map_mem #(
		.N   (N_OUT),
		.AW  (OAW),
		.RST (`PSL_OUT_MAP_RST)
	) u_out_map (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.wr_en    (out_wr),
		.wr_idx   (addr[OAW-1:0]),
		.wr_data  (wdata[4:0]),
		.rd_idx   (addr[OAW-1:0]),
		.rd_data  (out_rd),
		.map_flat (output_map_regs), // see RULE5
		.mismatch (out_mis)
	);

	// Mapping outputs are selections only: no enable, direction or
	// analog control leaves this block, so those stay with the pin
	// and peripheral logic. see RULE10 see RULE11 see RULE12

	// Mismatch reset request, registered
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			cfg_mismatch_rst <= 1'b0;
		else
			cfg_mismatch_rst <= in_mis | out_mis; // see RULE16
	end

	// Read path: remember source, mux after memory read register
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sel_q  <= 1'b0;
			rsrc_q <= 2'b00;
		end else begin
			sel_q  <= rd;
			rsrc_q <= in_hit ? 2'b01 : (out_hit ? 2'b10 : 2'b00);
		end
	end

	// Status word built in the strobe cycle for control reads
	reg [15:0] ctl_q;
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			ctl_q <= 16'h0000;
		else if (addr == `PSL_OSC_CTRL_ADDR)
			ctl_q <= {9'h000, lock_q, 6'h00};
		else if (addr == `PSL_STATUS_ADDR)
			ctl_q <= {12'h000, cfg_mismatch_rst, oneway_q,
			          sticky_q, lock_q};
		else
			ctl_q <= 16'h0000;
	end

	// Unmapped addresses read zero; data stand one cycle only
	always @* begin
		rdata = 16'h0000;
		if (sel_q) begin
			case (rsrc_q)
			2'b01:   rdata = {11'h000, in_rd};
			2'b10:   rdata = {11'h000, out_rd};
			default: rdata = ctl_q;
			endcase
		end
	end

endmodule // psl_lock_ctrl
`default_nettype wire

// ===== src/psl_map_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "psl_regs.vh"

// Bank of mapping fields, each paired with a shadow copy
module psl_map_mem #(
	parameter N   = 8,        // number of fields
	parameter AW  = 3,        // index width
	parameter RST = 5'h00     // reset value of every field
) (
	input  wire                  ref_clk,   // system clock
	input  wire                  rst,       // async reset, high
	input  wire                  wr_en,     // write one field
	input  wire [AW-1:0]         wr_idx,    // field to write
	input  wire [4:0]            wr_data,   // new field value
	input  wire [AW-1:0]         rd_idx,    // field to read
	output reg  [4:0]            rd_data,   // registered read data
	output wire [N*5-1:0]        map_flat,  // all fields, for routing
	output wire                  mismatch   // field differs from shadow
);

	wire [N-1:0] diff;

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_fld
			// Own registers per field: one driver each, no shared array
			localparam [AW-1:0] IDX = g;
			reg [4:0] fld_q;
			reg [4:0] shd_q;
			// Field and shadow update together, so any lone change shows
			always @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					fld_q <= RST; // see RULE5
					shd_q <= RST;
				end else if (wr_en && wr_idx == IDX) begin
					fld_q <= wr_data;
					shd_q <= wr_data;
				end
			end
			assign map_flat[g*5 +: 5] = fld_q;
			assign diff[g] = (fld_q != shd_q); // see RULE16
		end
	endgenerate

	assign mismatch = |diff;

	// Read data come from a register
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			rd_data <= 5'h00;
		else
			rd_data <= map_flat[rd_idx*5 +: 5];
	end

endmodule // psl_map_mem
`default_nettype wire

// ===== src/psl_regs.vh
`ifndef PSL_REGS_VH
`define PSL_REGS_VH

// Register offsets (word index on the plain register port)
`define PSL_OSC_CTRL_ADDR    8'h00
`define PSL_STATUS_ADDR      8'h01
`define PSL_IN_MAP_BASE      8'h10
`define PSL_OUT_MAP_BASE     8'h20

// Oscillator control low byte: lock bit position
`define PSL_LOCK_BIT         6

// Unlock key bytes, written in this order
`define PSL_KEY_FIRST        8'h46
`define PSL_KEY_SECOND       8'h57

// Mapping field width and reset values
`define PSL_FIELD_W          5
`define PSL_IN_MAP_RST       5'h1f
`define PSL_OUT_MAP_RST      5'h00

// Status register bit positions
`define PSL_ST_LOCK_BIT      0
`define PSL_ST_STICKY_BIT    1
`define PSL_ST_ONEWAY_BIT    2
`define PSL_ST_MISMATCH_BIT  3

`endif

// ===== verification/pin_select_lock_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pin_select_lock_control_tb;
	logic        ref_clk, rst, one_way_lock_cfg, wr, rd;
	logic [7:0]  addr;
	logic [15:0] wdata;
	wire  [15:0] rdata;
	wire  [39:0] input_map_regs, output_map_regs;
	wire         pin_map_lock, cfg_mismatch_rst;
	int          num_errors = 0, compares = 0;
	typedef struct packed {logic [7:0] a; logic [15:0] d, e;} psl_row_t;
	// Upper data bits must not leak into a field
	psl_row_t rows [4] = '{'{8'h10, 16'hffe3, 16'h0003},
		'{8'h20, 16'h0015, 16'h0015}, '{8'h27, 16'h001f, 16'h001f},
		'{8'h7f, 16'hffff, 16'h0000}};
	psl_lock_ctrl dut (.ref_clk, .rst, .one_way_lock_cfg, .addr, .wdata,
		.wr, .rd, .rdata, .input_map_regs, .output_map_regs,
		.pin_map_lock, .cfg_mismatch_rst);
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(string n, logic [39:0] e, logic [39:0] g);
		compares++;
		if (e !== g) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	// Strobe stays up so writes can run back to back
	task automatic put(logic [7:0] a, logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
	endtask
	task automatic get(logic [7:0] a, logic [15:0] e);
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
		@(posedge ref_clk);
	endtask
	task automatic lk(logic v);
		put(8'h00, 16'h0046);
		put(8'h00, 16'h0057);
		put(8'h00, {9'h0, v, 6'h0});
		wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rs(logic c);
		rst <= 1'b1;
		one_way_lock_cfg <= c;
		wr <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("in_map", {8{5'h1f}}, input_map_regs);
		chk("out_map", 40'h0, output_map_regs);
		chk("lock", 1'b0, pin_map_lock);
		chk("mismatch", 1'b0, cfg_mismatch_rst);
		rst <= 1'b0;
	endtask
	task automatic report_and_stop;
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		{rst, one_way_lock_cfg, wr, rd, addr, wdata} = {2'b01, 26'h0};
		// Reset rises in the task, once every process waits on it
		rs(1'b1);
		foreach (rows[i]) begin
			put(rows[i].a, rows[i].d);
			get(rows[i].a, rows[i].e);
		end
		put(8'h27, 16'h0000);
		get(8'h27, 16'h0000);
		lk(1'b1);
		chk("lock", 1'b1, pin_map_lock);
		get(8'h00, 16'h0040);
		lk(1'b0);
		chk("lock", 1'b1, pin_map_lock);
		put(8'h10, 16'h0009);
		get(8'h10, 16'h0003);
		get(8'h01, 16'h0007);
		rs(1'b0);
		// Wrong second key must drop the sequence
		put(8'h00, 16'h0046);
		put(8'h00, 16'h0058);
		put(8'h00, 16'h0040);
		// Let the last write land before looking at the lock
		wr <= 1'b0;
		@(posedge ref_clk);
		chk("lock", 1'b0, pin_map_lock);
		repeat (2) begin
			lk(1'b1);
			chk("lock", 1'b1, pin_map_lock);
			get(8'h01, 16'h0001);
			lk(1'b0);
			chk("lock", 1'b0, pin_map_lock);
		end
		put(8'h10, 16'h000a);
		get(8'h10, 16'h000a);
		report_and_stop();
	end
endmodule // pin_select_lock_control_tb
`default_nettype wire

// ===== verification/psl_lock_props.sv
`timescale 1ns/1ps
`default_nettype none
module psl_lock_props #(
	parameter N_IN  = 8,  // input fields
	parameter N_OUT = 8   // output fields
) (
	input wire logic               ref_clk,          // clock
	input wire logic               rst,              // reset
	input wire logic               one_way_lock_cfg, // mode
	input wire logic [7:0]         addr,             // address
	input wire logic [15:0]        wdata,            // data
	input wire logic               wr,               // write
	input wire logic               rd,               // read
	input wire logic [15:0]        rdata,            // read data
	input wire logic [N_IN*5-1:0]  input_map_regs,   // inputs
	input wire logic [N_OUT*5-1:0] output_map_regs,  // outputs
	input wire logic               pin_map_lock,     // lock
	input wire logic               cfg_mismatch_rst  // mismatch
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Both key bytes, back to back, open one lock change
	sequence keys_s;
		wr && addr == 8'h00 && wdata[7:0] == 8'h46 ##1
		wr && addr == 8'h00 && wdata[7:0] == 8'h57;
	endsequence
	sticky_hold_a: assert property (
		one_way_lock_cfg && pin_map_lock |=> pin_map_lock)
		else $error("lock cleared in one-way mode");
	map_frozen_a: assert property (
		pin_map_lock |=> $stable(input_map_regs) && $stable(output_map_regs))
		else $error("map changed while locked");
	// Reset must win even with the clock running
	in_reset_a: assert property (
		disable iff (1'b0) rst |-> input_map_regs == {N_IN{5'h1f}})
		else $error("input map reset value wrong");
	out_reset_a: assert property (
		disable iff (1'b0) rst |-> output_map_regs == '0 && !pin_map_lock)
		else $error("output map or lock reset wrong");
	map_write_a: assert property (
		wr && addr == 8'h10 && !pin_map_lock
		|=> input_map_regs[4:0] == $past(wdata[4:0]))
		else $error("open map write lost");
	unlock_set_a: assert property (
		keys_s ##1 (wr && addr == 8'h00 && !(one_way_lock_cfg && pin_map_lock))
		|=> pin_map_lock == $past(wdata[6]))
		else $error("lock change after keys missed");
	lock_cause_a: assert property (
		$changed(pin_map_lock) |-> $past(wr) && $past(addr) == 8'h00)
		else $error("lock moved without a write");
	status_read_a: assert property (
		rd && addr == 8'h01 |=> rdata[0] == $past(pin_map_lock)
		&& rdata[2] == $past(one_way_lock_cfg))
		else $error("status read wrong");
	no_mismatch_a: assert property (!cfg_mismatch_rst)
		else $error("shadow mismatch raised");
endmodule // psl_lock_props
bind psl_lock_ctrl psl_lock_props #(.N_IN(N_IN), .N_OUT(N_OUT)) u_props (
	.ref_clk, .rst, .one_way_lock_cfg, .addr, .wdata, .wr, .rd, .rdata,
	.input_map_regs, .output_map_regs, .pin_map_lock, .cfg_mismatch_rst);
`default_nettype wire
